/* File: src/lpm_cfg.svh */
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// Wake source vector bit positions
`define LPM_WK_RSTPIN   0
`define LPM_WK_IO       1
`define LPM_WK_RF       2
`define LPM_WK_BOR      3
`define LPM_WK_PVD      4
`define LPM_WK_PVM      5
`define LPM_WK_RTC      6
`define LPM_WK_INDEPENDENT_WATCHDOG     7
`define LPM_WK_COMP     8
`define LPM_WK_SER      9
`define LPM_WK_LPSER    10
`define LPM_WK_I2C      11
`define LPM_WK_LPTIM    12
`define LPM_WK_NUM      13

// Sequencing step time, regulator/clock settle
`define LPM_STEP_NS     20
`define LPM_STEP_CYC    ((`LPM_STEP_NS + 4) / 5)

// Reset values
`define LPM_FEAT_RST    1'b0

`endif

/* File: src/lpm_pkg.sv */
package lpm_pkg;
	typedef enum logic [2:0] {
		LPM_RUN      = 3'b000,
		LPM_LOW_POWER_RUN_MODE    = 3'b001,
		LPM_SLEEP    = 3'b011,
		LPM_LOW_POWER_SLEEP_MODE  = 3'b010,
		LPM_STOP0    = 3'b110,
		LPM_STOP1    = 3'b111,
		LPM_STANDBY  = 3'b101,
		LPM_SHUTDOWN = 3'b100
	} lpm_mode_e;

	typedef enum logic [2:0] {
		LPM_S_ACTIVE = 3'b000,
		LPM_S_CLK    = 3'b001,
		LPM_S_MEM    = 3'b011,
		LPM_S_LOW    = 3'b010,
		LPM_S_UNMEM  = 3'b110,
		LPM_S_UNCLK  = 3'b111
	} lpm_seq_e;
endpackage : lpm_pkg

/* File: src/lpm_osc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lpm_osc_if #(parameter int N = 4);
	logic [N-1:0] req;
	logic         allow;
	logic         osc_on;
	logic [N-1:0] route;
	modport ctl (input req, input allow, output osc_on, output route);
	modport src (output req, output allow, input osc_on, input route);
endinterface : lpm_osc_if
`default_nettype wire

/* File: src/lpm_osc_req.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_osc_req #(
	parameter int N = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	lpm_osc_if.ctl    o
);
	logic [N-1:0] route_q;
	logic [N-1:0] route_d;

	// [R2] Per-requester routing
	always_comb begin
		route_d = o.allow ? o.req : '0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			route_q <= '0;
		else if (ce)
			route_q <= route_d;
	end

	assign o.route  = route_q;
	// [R2] Off once no requester
	assign o.osc_on = |route_q;

	osc_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		ce && !o.allow |=> !o.osc_on)
		else $error("oscillator on without stop mode");
	osc_route_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		ce && o.allow |=> o.route == $past(o.req))
		else $error("oscillator routed to wrong peripheral");
endmodule : lpm_osc_req
`default_nettype wire

/* File: src/lpm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
// Overview of operation
// [R1] Optional per-mode features reset disabled; software enables them explicitly.
// [R2] Stop: peripherals request fast internal oscillator, routed only to requester.
// [R3] Serial receivers wake from stop on start, address match or frame.
// [R4] Two-wire target wakes from stop only on own address match.
// [R5] Only two wake-up pins wake from standby or shutdown; code also wakes on RTC, and in standby on reset pin, BOR, watchdog.
// [R6] I/O pull setting held in shutdown, dropped at shutdown exit.
// [R7] Low-power run/sleep: radio, random generator off, no PLL.
// [R8] Stop: flash off, SRAM kept, non-wake peripherals frozen.
// [R9] Stop exits on reset pin, I/O, radio, monitors, timers, serial.
// [R10] Standby offers SRAM-retained variant.
// [R11] Sleep gates each SRAM bank clock separately.
// [R12] Flash power-down only with radio unused and code in SRAM.
// [R13] Radio activity in stop enables external fast oscillator.
// [R14] I/Os analog with Schmitt trigger off under and after reset.
// [R15] Internal reset source disables reset pin pull-up.
// [R16] Main supply loss switches backup domain to battery.
// [R17] Battery-only operation not left on interrupts or calendar events.
// [R18] Battery charger enabled only with main supply present.
// [R19] Exactly one tamper input works in battery-only operation.
// [R20] Wait instruction enters mode; steps reversed on valid wake.
module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int NREQ = 4
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// Processor
	input  wire lpm_mode_e         mode_sel,
	input  wire logic              wait_exec,
	input  wire logic              irq_any,
	output logic                   cpu_run,
	output lpm_mode_e              mode_now,
	// Software options
	input  wire logic              sram_ret_en,
	input  wire logic              bank1_gate_en,
	input  wire logic              bank2_gate_en,
	input  wire logic              flash_pd_en,
	input  wire logic              code_in_sram,
	input  wire logic              charge_en,
	input  wire logic              pll_sel,
	// Wake sources, async pins
	input  wire logic              reset_pin_n,
	input  wire logic              first_wakeup_pin,
	input  wire logic              second_wakeup_pin,
	input  wire logic              io_event,
	input  wire logic              tamper_in,
	input  wire logic              main_supply_ok,
	// Wake sources, on-chip
	input  wire logic              radio_active,
	input  wire logic [`LPM_WK_NUM-1:0] wake_src,
	input  wire logic              ser_start,
	input  wire logic              ser_addr,
	input  wire logic              ser_frame,
	input  wire logic              i2c_addr_match,
	input  wire logic              rst_internal,
	input  wire logic [NREQ-1:0]   osc_req,
	// Power and clock controls
	output logic                   main_regulator,
	output logic                   low_power_regulator,
	output logic                   flash_on,
	output logic                   sram_on,
	output logic                   bank1_clk_en,
	output logic                   bank2_clk_en,
	output logic                   periph_freeze,
	output logic                   radio_rng_en,
	output logic                   pll_allowed,
	output logic                   ext_osc_on,
	output logic                   int_osc_on,
	output logic [NREQ-1:0]        int_osc_route,
	output logic                   ser_wake_irq,
	output logic                   i2c_wake_irq,
	// I/O and backup domain
	output logic                   io_analog,
	output logic                   io_pull_hold,
	output logic                   rst_pullup_en,
	output logic                   backup_on_battery,
	output logic                   charger_on,
	output logic                   tamper_det
);
	// Pin synchronisers, three stages
	logic [2:0] rp_s_q, w1_s_q, w2_s_q, io_s_q, tp_s_q, ms_s_q;
	logic [2:0] rp_s_d, w1_s_d, w2_s_d, io_s_d, tp_s_d, ms_s_d;
	logic rp_q, w1_q, w2_q, io_q, tp_q, ms_q;
	logic rp_d, w1_d, w2_d, io_d, tp_d, ms_d;

	always_comb begin
		rp_s_d = {rp_s_q[1:0], reset_pin_n};
		w1_s_d = {w1_s_q[1:0], first_wakeup_pin};
		w2_s_d = {w2_s_q[1:0], second_wakeup_pin};
		io_s_d = {io_s_q[1:0], io_event};
		tp_s_d = {tp_s_q[1:0], tamper_in};
		ms_s_d = {ms_s_q[1:0], main_supply_ok};
		rp_d = (rp_s_q[1] == rp_s_q[2]) ? rp_s_q[2] : rp_q;
		w1_d = (w1_s_q[1] == w1_s_q[2]) ? w1_s_q[2] : w1_q;
		w2_d = (w2_s_q[1] == w2_s_q[2]) ? w2_s_q[2] : w2_q;
		io_d = (io_s_q[1] == io_s_q[2]) ? io_s_q[2] : io_q;
		tp_d = (tp_s_q[1] == tp_s_q[2]) ? tp_s_q[2] : tp_q;
		ms_d = (ms_s_q[1] == ms_s_q[2]) ? ms_s_q[2] : ms_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{rp_s_q, w1_s_q, w2_s_q, io_s_q, tp_s_q, ms_s_q} <= '0;
			rp_s_q <= 3'h7;
			ms_s_q <= 3'h7;
			{w1_q, w2_q, io_q, tp_q} <= 4'h0;
			rp_q <= 1'b1;
			ms_q <= 1'b1;
		end else if (ce) begin
			{rp_s_q, w1_s_q, w2_s_q, io_s_q, tp_s_q, ms_s_q} <=
				{rp_s_d, w1_s_d, w2_s_d, io_s_d, tp_s_d, ms_s_d};
			{rp_q, w1_q, w2_q, io_q, tp_q, ms_q} <= {rp_d, w1_d, w2_d, io_d, tp_d, ms_d};
		end
	end

	// Sequencer
	lpm_seq_e  st_q, st_d;
	lpm_mode_e mode_q, mode_d;
	logic [7:0] cnt_q, cnt_d;
	logic       was_shut_q, was_shut_d;
	logic       reset_seen_q, reset_seen_d;
	logic       in_stop, in_lp, in_sleep, wake_ok, settle;
	logic [`LPM_WK_NUM-1:0] wk;

	// [R3] Serial wake events
	assign ser_wake_irq = (ser_start | ser_addr | ser_frame) & in_stop;
	// [R4] Address match only
	assign i2c_wake_irq = i2c_addr_match & in_stop;

	always_comb begin
		wk = wake_src;
		wk[`LPM_WK_RSTPIN] = !rp_q;
		wk[`LPM_WK_IO]     = io_q;
		wk[`LPM_WK_SER]    = ser_wake_irq;
		wk[`LPM_WK_LPSER]  = ser_wake_irq;
		wk[`LPM_WK_I2C]    = i2c_wake_irq;
	end

	assign in_stop  = (st_q != LPM_S_ACTIVE) &&
		(mode_q == LPM_STOP0 || mode_q == LPM_STOP1);
	assign in_sleep = (st_q != LPM_S_ACTIVE) &&
		(mode_q == LPM_SLEEP || mode_q == LPM_LOW_POWER_SLEEP_MODE);
	assign in_lp    = mode_q == LPM_LOW_POWER_RUN_MODE || mode_q == LPM_LOW_POWER_SLEEP_MODE;
	assign settle   = cnt_q == 8'h00;

	always_comb begin
		unique case (mode_q)
			LPM_SLEEP, LPM_LOW_POWER_SLEEP_MODE: wake_ok = irq_any;
			// [R9] Stop wake sources
			LPM_STOP0, LPM_STOP1:   wake_ok = |wk;
			// [R5] Two wake pins, reset pin, BOR, RTC and watchdog
			LPM_STANDBY:            wake_ok = w1_q | w2_q | !rp_q |
				wake_src[`LPM_WK_BOR] | wake_src[`LPM_WK_RTC] |
				wake_src[`LPM_WK_INDEPENDENT_WATCHDOG];
			LPM_SHUTDOWN:           wake_ok = w1_q | w2_q | wake_src[`LPM_WK_RTC];
			default:                wake_ok = 1'b0;
		endcase
	end

	// [R20] Enter on wait, reverse on wake
	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
		was_shut_d = 1'b0;
		reset_seen_d = rst_internal;
		unique case (st_q)
			LPM_S_ACTIVE: begin
				if (wait_exec && mode_sel != LPM_RUN && mode_sel != LPM_LOW_POWER_RUN_MODE) begin
					mode_d = mode_sel;
					st_d = LPM_S_CLK;
					cnt_d = 8'(`LPM_STEP_CYC);
				end else if (wait_exec) begin
					mode_d = mode_sel;
				end
			end
			LPM_S_CLK: if (settle) begin
				st_d = LPM_S_MEM;
				cnt_d = 8'(`LPM_STEP_CYC);
			end
			LPM_S_MEM: if (settle) begin
				st_d = LPM_S_LOW;
			end
			LPM_S_LOW: if (wake_ok) begin
				st_d = LPM_S_UNMEM;
				cnt_d = 8'(`LPM_STEP_CYC);
				was_shut_d = mode_q == LPM_SHUTDOWN;
			end
			LPM_S_UNMEM: if (settle) begin
				st_d = LPM_S_UNCLK;
				cnt_d = 8'(`LPM_STEP_CYC);
			end
			LPM_S_UNCLK: if (settle) begin
				st_d = LPM_S_ACTIVE;
				mode_d = in_lp ? LPM_LOW_POWER_RUN_MODE : LPM_RUN;
			end
			default: st_d = LPM_S_ACTIVE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= LPM_S_ACTIVE;
			mode_q <= LPM_RUN;
			cnt_q <= 8'h00;
			was_shut_q <= 1'b0;
			reset_seen_q <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			was_shut_q <= was_shut_d;
			reset_seen_q <= reset_seen_d;
		end
	end

	// Output state
	logic deep, deep_mem, shut_hold_q, shut_hold_d, anal_q, anal_d;
	assign deep = st_q == LPM_S_MEM || st_q == LPM_S_LOW;
	assign deep_mem = deep && (mode_q == LPM_STANDBY || mode_q == LPM_SHUTDOWN);

	always_comb begin
		shut_hold_d = shut_hold_q;
		// [R6] Hold in shutdown, drop on exit
		if (st_q == LPM_S_LOW && mode_q == LPM_SHUTDOWN)
			shut_hold_d = 1'b1;
		if (was_shut_d)
			shut_hold_d = 1'b0;
		// [R14] Analog until the first wait instruction
		anal_d = anal_q & !(st_q == LPM_S_ACTIVE && wait_exec);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shut_hold_q <= 1'b0;
			anal_q <= 1'b1;
		end else if (ce) begin
			shut_hold_q <= shut_hold_d;
			anal_q <= anal_d;
		end
	end

	assign mode_now = mode_q;
	assign cpu_run  = st_q == LPM_S_ACTIVE;
	assign main_regulator = !in_lp && !(deep && mode_q inside {LPM_STOP1, LPM_STANDBY,
		LPM_SHUTDOWN});
	// Regulator off where SRAM is dropped: shutdown and plain standby
	assign low_power_regulator = !main_regulator && !(deep_mem && !sram_on);
	// [R8] [R12] Flash power
	assign flash_on = !(deep && mode_q != LPM_SLEEP && mode_q != LPM_LOW_POWER_SLEEP_MODE) &&
		!(flash_pd_en && code_in_sram && !radio_active);
	// [R10] Standby retention variant, [R1] off by default
	assign sram_on = !(deep_mem && !(mode_q == LPM_STANDBY && sram_ret_en));
	// [R11] Independent bank gating
	assign bank1_clk_en = !(in_sleep && bank1_gate_en) && sram_on;
	assign bank2_clk_en = !(in_sleep && bank2_gate_en) && sram_on;
	// [R8] Freeze others in stop
	assign periph_freeze = in_stop && deep;
	// [R7] No radio, RANDOM_GENERATOR or PLL
	assign radio_rng_en = !in_lp && !deep_mem;
	assign pll_allowed  = !in_lp && pll_sel && !deep;
	// [R13] External oscillator for radio
	assign ext_osc_on = !deep || (in_stop && radio_active);
	assign io_analog = anal_q;
	assign io_pull_hold = shut_hold_q;
	// [R15] Pull-up off for internal reset
	assign rst_pullup_en = !rst_internal && !reset_seen_q;
	// [R16] [R17] Battery follows supply only
	assign backup_on_battery = !ms_q;
	// [R18] Charger needs main supply
	assign charger_on = charge_en && ms_q;
	// [R19] Single tamper input kept
	assign tamper_det = tp_q;

	lpm_osc_if #(.N(NREQ)) osc_bus ();
	assign osc_bus.req = osc_req;
	assign osc_bus.allow = in_stop;
	assign int_osc_on = osc_bus.osc_on;
	assign int_osc_route = osc_bus.route;

	lpm_osc_req #(.N(NREQ)) u_osc (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.o       (osc_bus)
	);

	// [R18]
	chg_a: assert property (@(posedge clk) disable iff (sys_rst)
		charger_on |-> ms_q) else $error("charger on without main supply");
	// [R7]
	lp_pll_a: assert property (@(posedge clk) disable iff (sys_rst)
		in_lp |-> !pll_allowed && !radio_rng_en) else $error("pll in low power");
	// [R13]
	ext_osc_a: assert property (@(posedge clk) disable iff (sys_rst)
		in_stop && radio_active |-> ext_osc_on) else $error("radio without oscillator");
	// [R4]
	i2c_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
		i2c_wake_irq |-> i2c_addr_match) else $error("i2c wake without match");
	// [R5]
	sd_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
		st_q == LPM_S_LOW && mode_q == LPM_SHUTDOWN && !w1_q && !w2_q &&
		!wake_src[`LPM_WK_RTC] |=> st_q == LPM_S_LOW) else $error("bad shutdown wake");
	// [R6]
	pull_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && was_shut_d |=> !io_pull_hold) else $error("pull kept after shutdown");
	// [R8]
	stop_flash_a: assert property (@(posedge clk) disable iff (sys_rst)
		periph_freeze |-> !flash_on && sram_on) else $error("stop memory wrong");
	// [R16]
	bat_sw_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && !ms_d |=> backup_on_battery) else $error("no battery switch");
	// [R20]
	seq_back_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && st_q == LPM_S_LOW && wake_ok |=> st_q == LPM_S_UNMEM) else $error("no wake");
endmodule : lpm_ctrl
`default_nettype wire

/* File: tb/lpm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_cpu_model
	import lpm_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Commands from the bench
	input  wire logic              enter,
	input  wire lpm_mode_e         target,
	input  wire logic              wake,
	input  wire logic [3:0]        wake_idx,
	// Controller side
	input  wire logic              cpu_run,
	output lpm_mode_e              mode_sel,
	output logic                   wait_exec,
	output logic [`LPM_WK_NUM-1:0] wake_src
);
	initial begin
		mode_sel = LPM_RUN;
		wait_exec = 1'b0;
		wake_src = '0;
	end
	always @(posedge clk) begin
		wait_exec <= #1 enter;
		if (enter) mode_sel <= #1 target;
		wake_src <= #1 (wake && !cpu_run) ? (`LPM_WK_NUM'(1) << wake_idx) : '0;
	end
endmodule : lpm_cpu_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module testbench;
	import lpm_pkg::*;
	typedef struct {lpm_mode_e m; logic [3:0] wk; logic fl; logic fz; logic random_generator;} lpm_row_s;
	logic clk = 1'b0, sys_rst = 1'b1, irq_any = 1'b0, sram_ret_en = 1'b0, bank1_gate_en = 1'b0;
	logic bank2_gate_en = 1'b0, flash_pd_en = 1'b0, code_in_sram = 1'b0, charge_en = 1'b0;
	logic pll_sel = 1'b0, reset_pin_n = 1'b1, first_wakeup_pin = 1'b0, second_wakeup_pin = 1'b0;
	logic io_event = 1'b0, tamper_in = 1'b0, main_supply_ok = 1'b1, radio_active = 1'b0;
	logic ser_start = 1'b0, ser_addr = 1'b0, ser_frame = 1'b0, i2c_addr_match = 1'b0;
	logic rst_internal = 1'b0, enter = 1'b0, wake = 1'b0, ce = 1'b1;
	logic [3:0] osc_req = 4'h0, wake_idx = 4'h0, int_osc_route;
	lpm_mode_e target = LPM_RUN, mode_sel, mode_now;
	logic [`LPM_WK_NUM-1:0] wake_src;
	logic wait_exec, cpu_run, main_regulator, low_power_regulator, flash_on, sram_on;
	logic bank1_clk_en, bank2_clk_en, periph_freeze, radio_rng_en, pll_allowed, ext_osc_on;
	logic int_osc_on, ser_wake_irq, i2c_wake_irq, io_analog, io_pull_hold, rst_pullup_en;
	logic backup_on_battery, charger_on, tamper_det;
	int miscompares = 0;
	int checked = 0;
	lpm_row_s rows [15] = '{
		'{LPM_SLEEP, 4'hF, 1'b1, 1'b0, 1'b1}, '{LPM_LOW_POWER_SLEEP_MODE, 4'hF, 1'b1, 1'b0, 1'b0},
		'{LPM_STOP0, 4'h0, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'h1, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'h2, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'h3, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'h4, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'h5, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'h6, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'h7, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'h8, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'h9, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'hA, 1'b0, 1'b1, 1'b0}, '{LPM_STOP1, 4'hB, 1'b0, 1'b1, 1'b0},
		'{LPM_STOP0, 4'hC, 1'b0, 1'b1, 1'b0}};

	always #2.5 clk = ~clk;

	lpm_cpu_model cpu (.clk, .enter, .target, .wake, .wake_idx, .cpu_run, .mode_sel,
		.wait_exec, .wake_src);

	lpm_ctrl #(.NREQ(4)) dut (.clk, .sys_rst, .ce, .mode_sel, .wait_exec, .irq_any,
		.cpu_run, .mode_now, .sram_ret_en, .bank1_gate_en, .bank2_gate_en, .flash_pd_en,
		.code_in_sram, .charge_en, .pll_sel, .reset_pin_n, .first_wakeup_pin,
		.second_wakeup_pin, .io_event, .tamper_in, .main_supply_ok, .radio_active, .wake_src,
		.ser_start, .ser_addr, .ser_frame, .i2c_addr_match, .rst_internal, .osc_req,
		.main_regulator, .low_power_regulator, .flash_on, .sram_on, .bank1_clk_en,
		.bank2_clk_en, .periph_freeze, .radio_rng_en, .pll_allowed, .ext_osc_on, .int_osc_on,
		.int_osc_route, .ser_wake_irq, .i2c_wake_irq, .io_analog, .io_pull_hold,
		.rst_pullup_en, .backup_on_battery, .charger_on, .tamper_det);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic issue(input lpm_mode_e m);
		target = m;
		enter = 1'b1;
		cyc(1);
		enter = 1'b0;
	endtask : issue

	// Entry walk is ten cycles after the wait pulse
	task automatic go(input lpm_mode_e m);
		issue(m);
		cyc(13);
	endtask : go

	// 15 wakes by interrupt, 14 by a pin already set
	task automatic wake_by(input int k);
		// Reset pin, I/O, serial and two-wire bits come from their own inputs
		if (k == 15) irq_any = 1'b1;
		else if (k == 0) reset_pin_n = 1'b0;
		else if (k == 1) io_event = 1'b1;
		else if (k == 9 || k == 10) ser_frame = 1'b1;
		else if (k == 11) i2c_addr_match = 1'b1;
		else if (k < 13) begin
			wake_idx = k[3:0];
			wake = 1'b1;
		end
		for (int n = 0; n < 40 && cpu_run !== 1'b1; n++) cyc(1);
		chk(cpu_run, 1'b1, "no return to run");
		irq_any = 1'b0;
		wake = 1'b0;
		reset_pin_n = 1'b1;
		io_event = 1'b0;
		ser_frame = 1'b0;
		i2c_addr_match = 1'b0;
		cyc(2);
	endtask : wake_by

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		#50000;
		miscompares++;
		stop_test;
	end

	initial begin
		cyc(8);
		chk(io_analog, 1'b1, "pins not analog in reset");
		sys_rst = 1'b0;
		cyc(2);
		chk(io_analog, 1'b1, "pins not analog after reset");
		chk(charger_on, 1'b0, "charger on by default");
		chk({bank1_clk_en, bank2_clk_en, flash_on}, 3'h7, "feature on by default");
		chk(mode_now, LPM_RUN, "reset mode");
		rst_internal = 1'b1;
		cyc(2);
		chk(rst_pullup_en, 1'b0, "pull-up kept on internal reset");
		rst_internal = 1'b0;
		flash_pd_en = 1'b1;
		code_in_sram = 1'b1;
		radio_active = 1'b1;
		cyc(2);
		chk(flash_on, 1'b1, "flash off with radio busy");
		chk(rst_pullup_en, 1'b1, "pull-up off after internal reset");
		radio_active = 1'b0;
		cyc(2);
		chk(flash_on, 1'b0, "flash not powered down");
		flash_pd_en = 1'b0;
		$display("test reset done");
		ce = 1'b0;
		go(LPM_LOW_POWER_RUN_MODE);
		chk(mode_now, LPM_RUN, "wait taken with clock enable low");
		ce = 1'b1;
		pll_sel = 1'b1;
		go(LPM_LOW_POWER_RUN_MODE);
		chk(mode_now, LPM_LOW_POWER_RUN_MODE, "low-power run not entered");
		chk({main_regulator, low_power_regulator}, 2'h1, "regulator in low-power run");
		chk({radio_rng_en, pll_allowed}, 2'h0, "radio or pll in low-power run");
		go(LPM_RUN);
		chk(radio_rng_en, 1'b1, "radio off in run");
		chk(io_analog, 1'b0, "pins analog after wait");
		$display("test run modes done");
		foreach (rows[i]) begin
			bank1_gate_en = (i == 0);
			bank2_gate_en = (i == 1);
			go(rows[i].m);
			chk(cpu_run, 1'b0, "core still running");
			chk({main_regulator, low_power_regulator},
				(rows[i].m inside {LPM_SLEEP, LPM_STOP0}) ? 2'h2 : 2'h1, "regulator");
			chk({flash_on, periph_freeze, sram_on}, {rows[i].fl, rows[i].fz, 1'b1}, "power");
			if (rows[i].m inside {LPM_SLEEP, LPM_LOW_POWER_SLEEP_MODE}) begin
				chk(radio_rng_en, rows[i].random_generator, "radio state in sleep");
				chk({bank1_clk_en, bank2_clk_en}, {!bank1_gate_en, !bank2_gate_en},
					"bank clock gating");
			end
			wake_by(rows[i].wk);
		end
		bank1_gate_en = 1'b0;
		bank2_gate_en = 1'b0;
		$display("test mode table done");
		issue(LPM_STOP1);
		cyc(2);
		wake = 1'b1;
		cyc(2);
		wake = 1'b0;
		cyc(12);
		chk(cpu_run, 1'b0, "wake taken during entry");
		osc_req = 4'hA;
		cyc(3);
		chk({int_osc_on, int_osc_route}, 5'h1A, "oscillator request");
		osc_req = 4'h0;
		cyc(3);
		chk({int_osc_on, int_osc_route}, 5'h00, "oscillator left on");
		chk(ext_osc_on, 1'b0, "external oscillator on without radio");
		radio_active = 1'b1;
		cyc(2);
		chk(ext_osc_on, 1'b1, "external oscillator off");
		radio_active = 1'b0;
		wake_by(2);
		for (int k = 0; k < 3; k++) begin
			go(LPM_STOP0);
			{ser_frame, ser_addr, ser_start} = 3'h1 << k;
			cyc(2);
			chk(ser_wake_irq, 1'b1, "serial wake missing");
			{ser_frame, ser_addr, ser_start} = 3'h0;
			wake_by(9);
		end
		go(LPM_STOP1);
		chk(i2c_wake_irq, 1'b0, "two-wire wake without match");
		i2c_addr_match = 1'b1;
		cyc(2);
		chk(i2c_wake_irq, 1'b1, "two-wire wake missing");
		i2c_addr_match = 1'b0;
		wake_by(11);
		$display("test stop done");
		go(LPM_STANDBY);
		chk(sram_on, 1'b0, "sram kept in standby");
		chk({main_regulator, low_power_regulator}, 2'h0, "regulator on in standby");
		wake_idx = 4'h1;
		wake = 1'b1;
		io_event = 1'b1;
		cyc(20);
		chk(cpu_run, 1'b0, "standby left by plain pin");
		wake = 1'b0;
		io_event = 1'b0;
		first_wakeup_pin = 1'b1;
		wake_by(14);
		first_wakeup_pin = 1'b0;
		sram_ret_en = 1'b1;
		go(LPM_STANDBY);
		chk(sram_on, 1'b1, "sram not retained");
		chk({main_regulator, low_power_regulator}, 2'h1, "retention regulator off");
		second_wakeup_pin = 1'b1;
		wake_by(14);
		second_wakeup_pin = 1'b0;
		sram_ret_en = 1'b0;
		go(LPM_SHUTDOWN);
		chk(io_pull_hold, 1'b1, "pull setting dropped");
		first_wakeup_pin = 1'b1;
		wake_by(14);
		first_wakeup_pin = 1'b0;
		chk(io_pull_hold, 1'b0, "pull setting kept");
		$display("test standby done");
		go(LPM_STOP0);
		sys_rst = 1'b1;
		cyc(2);
		chk({cpu_run, io_analog, mode_now}, {2'h3, LPM_RUN}, "state through reset");
		sys_rst = 1'b0;
		cyc(2);
		chk({cpu_run, periph_freeze}, 2'h2, "not running after reset");
		$display("test mid-run reset done");
		charge_en = 1'b1;
		cyc(2);
		chk(charger_on, 1'b1, "charger not on");
		main_supply_ok = 1'b0;
		cyc(6);
		chk(backup_on_battery, 1'b1, "no battery switch");
		chk(charger_on, 1'b0, "charger on battery");
		irq_any = 1'b1;
		io_event = 1'b1;
		cyc(6);
		chk(backup_on_battery, 1'b1, "battery left on event");
		tamper_in = 1'b1;
		cyc(6);
		chk(tamper_det, 1'b1, "tamper not seen");
		$display("test battery done");
		stop_test;
	end
endmodule : testbench
`default_nettype wire
